// File: scsc_assertions.sv
// assertions for the calibration and state command block
`timescale 1ns/10ps
module scsc_assertions (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic SDA_O,
    input wire logic SLEEP_ENTER,
    input wire logic SAMPLE_VALID,
    input wire logic FILT_VALID,
    input wire logic [15:0] FILT_DATA,
    input wire logic TRACK_EN,
    input wire logic [31:0] OFFSET_WORD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    chk_wait_once: assert property ($rose(AVS_READ | AVS_WRITE) |=> !AVS_WAITREQUEST)
        else $error("no answer");
    chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long");
    chk_od_low: assert property (SDA_O == 1'b0) else $error("sda high");
    chk_filt_follow: assert property (SAMPLE_VALID |=> FILT_VALID) else $error("no out");
    chk_filt_cause: assert property (FILT_VALID |-> $past(SAMPLE_VALID)) else $error("stray");
    chk_filt_hold: assert property (!FILT_VALID && !$past(SLEEP_ENTER) |-> $stable(FILT_DATA))
        else $error("drift");
    chk_sleep_wipe: assert property (SLEEP_ENTER |=> !TRACK_EN && OFFSET_WORD == 32'h0)
        else $error("kept");
    chk_reset_clear: assert property ($fell(RESET) |-> !TRACK_EN && FILT_DATA == 16'h0)
        else $error("not clear");
    cover property (AVS_READ && !AVS_WAITREQUEST);
    cover property (FILT_VALID);
    cover property (SLEEP_ENTER);
endmodule : scsc_assertions
bind scsc_top scsc_assertions u_scsc_assertions (.CLK, .RESET, .AVS_READ, .AVS_WRITE,
    .AVS_WAITREQUEST, .SDA_O, .SLEEP_ENTER, .SAMPLE_VALID, .FILT_VALID, .FILT_DATA, .TRACK_EN,
    .OFFSET_WORD);

// File: scsc_host.sv
// host i2c master model
`timescale 1ns/10ps
module scsc_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bw(input logic b);
        sda_low = !b;
        #31.25 scl = 1'b1;
        #62.5 scl = 1'b0;
        #31.25;
    endtask : bw
    task automatic br(output logic b);
        sda_low = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 b = sda;
        #31.25 scl = 1'b0;
        #31.25;
    endtask : br
    function automatic logic [7:0] crc(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc
    task automatic xfer(input logic [7:0] q[$], input int n, output logic [7:0] rd[$],
                        output logic ok);
        logic b;
        logic [7:0] d;
        ok = 1'b1;
        rd = {};
        sda_low = 1'b1;
        #31.25 scl = 1'b0;
        #31.25;
        foreach (q[i]) if (ok) begin
            for (int k = 7; k >= 0; k--) bw(q[i][k]);
            br(b);
            ok = !b;
        end
        for (int i = 0; i < n && ok; i++) begin
            for (int k = 7; k >= 0; k--) begin
                br(b);
                d[k] = b;
            end
            rd.push_back(d);
            bw(i == n - 1);
        end
        sda_low = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 sda_low = 1'b0;
        #62.5;
    endtask : xfer
endmodule : scsc_host

// File: scsc_params.svh
// constants for the calibration and state command block
`ifndef SCSC_PARAMS_SVH
`define SCSC_PARAMS_SVH
`define SCSC_CMD_TRK_ON 16'h3fef
`define SCSC_CMD_TRK_OFF 16'h3f6e
`define SCSC_CMD_WEAK_ON 16'h3fc8
`define SCSC_CMD_WEAK_OFF 16'h3f49
`define SCSC_CMD_STRG_ON 16'h3fd5
`define SCSC_CMD_STRG_OFF 16'h3f54
`define SCSC_CMD_SELFTEST 16'h365b
`define SCSC_CMD_PREP 16'h3752
`define SCSC_CMD_STATE 16'he133
`define SCSC_CMD_APPLY 16'h3650
`define SCSC_CMD_OFS_RD 16'h370a
`define SCSC_CMD_OFS_WR 16'h3608
`define SCSC_GC_ADDR 8'h00
`define SCSC_GC_RESET 8'h06
`define SCSC_DEV_ADDR 7'h2a
`define SCSC_CRC_POLY 8'h31
`define SCSC_CRC_INIT 8'hff
`define SCSC_STATE_WORDS 4'ha
`define SCSC_W_TRACK 1
`define SCSC_W_OFS_HI 4
`define SCSC_W_OFS_LO 5
`define SCSC_WEAK_A 9'h09a
`define SCSC_STRG_A 9'h0de
`define SCSC_ONE 9'h100
`define SCSC_REG_CTRL 4'h0
`define SCSC_REG_TEST 4'h1
`define SCSC_REG_LIVE0 4'h2
`define SCSC_CTRL_TRK 0
`define SCSC_CTRL_WEAK 1
`define SCSC_CTRL_STRG 2
`define SCSC_CTRL_BUSY 8
`define SCSC_CTRL_HOLD 9
`define SCSC_CLK_MHZ 100
`define SCSC_ST_TIME_US 30000
`define SCSC_RST_TIME_US 12000
`endif

// File: scsc_pkg.sv
// types for the calibration and state command block
package scsc_pkg;
    typedef enum logic [6:0] {
        SCSC_IDLE = 7'h01,
        SCSC_ADDR = 7'h02,
        SCSC_ACKA = 7'h04,
        SCSC_RXB = 7'h08,
        SCSC_ACKR = 7'h10,
        SCSC_TXB = 7'h20,
        SCSC_ACKT = 7'h40
    } scsc_st_t;
    typedef enum logic [2:0] {
        SCSC_RM_NONE = 3'h1,
        SCSC_RM_TEST = 3'h2,
        SCSC_RM_STATE = 3'h4
    } scsc_rm_t;
    typedef logic [15:0] scsc_word_t;
endpackage : scsc_pkg

// File: scsc_top.sv
// i2c target for calibration, filter, self-test, reset and state commands
`timescale 1ns/10ps
`include "scsc_params.svh"
//
// Function
// - commands 0x3fef/0x3f6e switch offset tracking on/off; off after start-up
// - tracking correction is cleared on power cycle, reset and sleep
// - 0x3fc8/0x3f49 switch weak filter: 0.6 old plus 0.4 new
// - 0x3fd5/0x3f54 switch strong filter: 0.867 old plus 0.133 new
// - filters off at start-up; once on, applied to every later result except the first, which passes through and seeds the history
// - both filters may run together, weak then strong in series
// - filter history is lost on sleep; restart without history
// - 0x365b runs self-test under 30ms; result word plus checksum
// - bits 1:0 memory error, bit 2 supply out of range, 9:3 debug, 15:10 always zero
// - self-test checks memory and supply range, reported in the word
// - general call 0x00 with byte 0x06 triggers a soft reset
// - power-up state within 12ms; no address ack nor commands meanwhile (the 12ms hold follows only the 0x06 soft reset, not RESET)
// - gas model and offset references sit in volatile storage
// - 0x3752 stages the current state; host waits 2 ms
// - read 0xe133 returns ten words each with checksum, 30 bytes
// - write 0xe133 with 30-byte image loads the pending state buffer
// - 0x3650 adopts the pending state; host waits 2 ms
// - image holds gas, tracking flag/offset, offset and compensation inputs
// - 0x370a reads upper 16 offset bits; 0x3608 loads them, lower cleared
// - checksum is crc-8, poly 0x31, init 0xff, no reflection or xor
// - sleep wipes volatile settings exactly like a power cycle
module scsc_top #(
    parameter int ST_CYC = `SCSC_ST_TIME_US * `SCSC_CLK_MHZ,
    parameter int RST_CYC = `SCSC_RST_TIME_US * `SCSC_CLK_MHZ
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SLEEP_ENTER,
    input wire logic [1:0] MEM_ERR,
    input wire logic VDD_OK,
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] SAMPLE_DATA,
    output logic FILT_VALID,
    output logic [15:0] FILT_DATA,
    output logic TRACK_EN,
    output logic [31:0] OFFSET_WORD
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = `SCSC_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ `SCSC_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc8

    function automatic logic [15:0] ema(input logic [15:0] y, input logic [15:0] x,
                                        input logic [8:0] a);
        logic [24:0] s;
        s = 25'(a) * 25'(y) + 25'(`SCSC_ONE - a) * 25'(x) + 25'h0000080;
        return s[23:8];
    endfunction : ema

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    scsc_pkg::scsc_st_t st_q;
    scsc_pkg::scsc_rm_t rm_q;
    scsc_pkg::scsc_word_t live_q [0:9];
    scsc_pkg::scsc_word_t stage_q [0:9];
    scsc_pkg::scsc_word_t pend_q [0:9];
    scsc_pkg::scsc_word_t test_q;
    scsc_pkg::scsc_word_t argw_q;
    scsc_pkg::scsc_word_t txw;
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic rise, fall, start, stop;
    logic [3:0] bitc_q;
    logic [7:0] sh_q, cmdh_q, tx_q, tx_d;
    logic [15:0] cmd_q;
    logic [5:0] rxn_q;
    logic [3:0] aw_q, tw_q;
    logic [1:0] ap_q, tp_q;
    logic rw_q, gc_q, oe_q;
    logic cmd_go_q, arg_go_q, soft_go_q;
    logic [3:0] arg_idx_q;
    logic crc_ok, addr_ok;
    logic [21:0] st_cnt_q;
    logic [20:0] hold_cnt_q;
    logic st_busy_q, hold_q, clr, wipe;
    logic weak_q, strg_q, h1_q, h2_q;
    logic [15:0] s1, s2, y1_q;
    logic wait_q;
    logic [31:0] rdata_q, rd_mux;
    logic avw;

    assign clr = RESET || soft_go_q;
    assign wipe = clr || SLEEP_ENTER;
    assign SDA_O = 1'b0;
    assign SDA_OE = oe_q;
    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;
    assign TRACK_EN = live_q[`SCSC_W_TRACK][0];
    assign OFFSET_WORD = {live_q[`SCSC_W_OFS_HI], live_q[`SCSC_W_OFS_LO]};

    // ------------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= SCL_I;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= SDA_I;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    assign rise = scl_s_q && !scl_p_q;
    assign fall = !scl_s_q && scl_p_q;
    assign start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    assign stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    assign crc_ok = crc8(argw_q) == sh_q;
    // no ack while reset settles, nor a read header while testing
    assign addr_ok = !hold_q && ((sh_q[7:1] == `SCSC_DEV_ADDR && !(sh_q[0] && st_busy_q))
                     || sh_q == `SCSC_GC_ADDR);

    // ------------------------------------------------------------------
    // transmit byte source
    // ------------------------------------------------------------------
    always_comb begin
        txw = 16'hffff;
        unique case (rm_q)
            scsc_pkg::SCSC_RM_TEST: txw = test_q;
            scsc_pkg::SCSC_RM_STATE: txw = stage_q[tw_q];
            scsc_pkg::SCSC_RM_NONE: txw = live_q[`SCSC_W_OFS_HI];
        endcase
        if (tp_q == 2'h0) begin
            tx_d = txw[15:8];
        end else if (tp_q == 2'h1) begin
            tx_d = txw[7:0];
        end else begin
            tx_d = crc8(txw);
        end
        if (tw_q >= `SCSC_STATE_WORDS || (rm_q != scsc_pkg::SCSC_RM_STATE && tw_q != 4'h0)) begin
            tx_d = 8'hff;
        end
    end

    // ------------------------------------------------------------------
    // i2c target engine
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        cmd_go_q <= 1'b0;
        arg_go_q <= 1'b0;
        soft_go_q <= 1'b0;
        if (clr) begin
            st_q <= scsc_pkg::SCSC_IDLE;
            bitc_q <= 4'h0;
            sh_q <= 8'h00;
            cmdh_q <= 8'h00;
            cmd_q <= 16'h0000;
            tx_q <= 8'hff;
            rxn_q <= 6'h00;
            aw_q <= 4'h0;
            ap_q <= 2'h0;
            tw_q <= 4'h0;
            tp_q <= 2'h0;
            argw_q <= 16'h0000;
            arg_idx_q <= 4'h0;
            rw_q <= 1'b0;
            gc_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (start) begin
            st_q <= scsc_pkg::SCSC_ADDR;
            bitc_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop) begin
            st_q <= scsc_pkg::SCSC_IDLE;
            oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                scsc_pkg::SCSC_IDLE: begin
                    oe_q <= 1'b0;
                end
                scsc_pkg::SCSC_ADDR, scsc_pkg::SCSC_RXB: begin
                    if (rise) begin
                        sh_q <= {sh_q[6:0], sda_s_q};
                        bitc_q <= bitc_q + 4'h1;
                    end else if (fall && bitc_q == 4'h8) begin
                        if (st_q == scsc_pkg::SCSC_ADDR) begin
                            if (addr_ok) begin
                                oe_q <= 1'b1;
                                st_q <= scsc_pkg::SCSC_ACKA;
                                rw_q <= sh_q[0];
                                gc_q <= sh_q == `SCSC_GC_ADDR;
                                rxn_q <= 6'h00;
                                aw_q <= 4'h0;
                                ap_q <= 2'h0;
                                tw_q <= 4'h0;
                                tp_q <= 2'h0;
                            end else begin
                                st_q <= scsc_pkg::SCSC_IDLE;
                            end
                        end else if (gc_q) begin
                            soft_go_q <= sh_q == `SCSC_GC_RESET;
                            oe_q <= 1'b1;
                            st_q <= scsc_pkg::SCSC_ACKR;
                        end else if (rxn_q == 6'h00) begin
                            cmdh_q <= sh_q;
                            rxn_q <= 6'h01;
                            oe_q <= 1'b1;
                            st_q <= scsc_pkg::SCSC_ACKR;
                        end else if (rxn_q == 6'h01) begin
                            cmd_q <= {cmdh_q, sh_q};
                            cmd_go_q <= 1'b1;
                            rxn_q <= 6'h02;
                            oe_q <= 1'b1;
                            st_q <= scsc_pkg::SCSC_ACKR;
                        end else if (ap_q == 2'h0) begin
                            argw_q[15:8] <= sh_q;
                            ap_q <= 2'h1;
                            oe_q <= 1'b1;
                            st_q <= scsc_pkg::SCSC_ACKR;
                        end else if (ap_q == 2'h1) begin
                            argw_q[7:0] <= sh_q;
                            ap_q <= 2'h2;
                            oe_q <= 1'b1;
                            st_q <= scsc_pkg::SCSC_ACKR;
                        end else if (crc_ok && aw_q < `SCSC_STATE_WORDS) begin
                            // word taken only with a good checksum
                            arg_go_q <= 1'b1;
                            arg_idx_q <= aw_q;
                            aw_q <= aw_q + 4'h1;
                            ap_q <= 2'h0;
                            oe_q <= 1'b1;
                            st_q <= scsc_pkg::SCSC_ACKR;
                        end else begin
                            st_q <= scsc_pkg::SCSC_IDLE;
                        end
                    end
                end
                scsc_pkg::SCSC_ACKA, scsc_pkg::SCSC_ACKR: begin
                    if (fall) begin
                        bitc_q <= 4'h0;
                        if (st_q == scsc_pkg::SCSC_ACKA && rw_q) begin
                            tx_q <= tx_d;
                            oe_q <= !tx_d[7];
                            st_q <= scsc_pkg::SCSC_TXB;
                        end else begin
                            oe_q <= 1'b0;
                            st_q <= scsc_pkg::SCSC_RXB;
                        end
                    end
                end
                scsc_pkg::SCSC_TXB: begin
                    if (rise) begin
                        bitc_q <= bitc_q + 4'h1;
                    end else if (fall) begin
                        if (bitc_q == 4'h8) begin
                            oe_q <= 1'b0;
                            st_q <= scsc_pkg::SCSC_ACKT;
                            if (tp_q == 2'h2) begin
                                tp_q <= 2'h0;
                                tw_q <= tw_q + 4'h1;
                            end else begin
                                tp_q <= tp_q + 2'h1;
                            end
                        end else begin
                            oe_q <= !tx_q[3'(4'h7 - bitc_q)];
                        end
                    end
                end
                scsc_pkg::SCSC_ACKT: begin
                    if (rise && sda_s_q) begin
                        st_q <= scsc_pkg::SCSC_IDLE;
                    end else if (fall) begin
                        bitc_q <= 4'h0;
                        tx_q <= tx_d;
                        oe_q <= !tx_d[7];
                        st_q <= scsc_pkg::SCSC_TXB;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read source selection
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (clr) begin
            rm_q <= scsc_pkg::SCSC_RM_NONE;
        end else if (cmd_go_q) begin
            if (cmd_q == `SCSC_CMD_SELFTEST) begin
                rm_q <= scsc_pkg::SCSC_RM_TEST;
            end else if (cmd_q == `SCSC_CMD_STATE || cmd_q == `SCSC_CMD_PREP) begin
                rm_q <= scsc_pkg::SCSC_RM_STATE;
            end else begin
                rm_q <= scsc_pkg::SCSC_RM_NONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // soft reset hold and self-test
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            hold_q <= 1'b0;
            hold_cnt_q <= 21'h000000;
        end else if (soft_go_q) begin
            hold_q <= 1'b1;
            hold_cnt_q <= 21'h000000;
        end else if (hold_q) begin
            hold_cnt_q <= hold_cnt_q + 21'h000001;
            hold_q <= hold_cnt_q < 21'(RST_CYC - 1);
        end
    end

    always_ff @(posedge CLK) begin
        if (wipe) begin
            st_busy_q <= 1'b0;
            st_cnt_q <= 22'h000000;
            test_q <= 16'h0000;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_SELFTEST) begin
            st_busy_q <= 1'b1;
            st_cnt_q <= 22'h000000;
        end else if (st_busy_q) begin
            st_cnt_q <= st_cnt_q + 22'h000001;
            if (st_cnt_q >= 22'(ST_CYC - 1)) begin
                st_busy_q <= 1'b0;
                test_q <= {6'h00, 7'h00, !VDD_OK, MEM_ERR};
            end
        end
    end

    // ------------------------------------------------------------------
    // volatile state image
    // ------------------------------------------------------------------
    assign avw = AVS_WRITE && !wait_q;

    always_ff @(posedge CLK) begin
        if (wipe) begin
            for (int i = 0; i < 10; i++) begin
                live_q[i] <= 16'h0000;
            end
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_TRK_ON) begin
            live_q[`SCSC_W_TRACK] <= 16'h0001;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_TRK_OFF) begin
            live_q[`SCSC_W_TRACK] <= 16'h0000;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_APPLY) begin
            for (int i = 0; i < 10; i++) begin
                live_q[i] <= pend_q[i];
            end
        end else if (arg_go_q && cmd_q == `SCSC_CMD_OFS_WR && arg_idx_q == 4'h0) begin
            live_q[`SCSC_W_OFS_HI] <= argw_q;
            live_q[`SCSC_W_OFS_LO] <= 16'h0000;
        end else if (avw && AVS_ADDRESS == `SCSC_REG_CTRL) begin
            live_q[`SCSC_W_TRACK] <= {15'h0000, AVS_WRITEDATA[`SCSC_CTRL_TRK]};
        end else if (avw && AVS_ADDRESS >= `SCSC_REG_LIVE0) begin
            live_q[4'(AVS_ADDRESS - `SCSC_REG_LIVE0)] <= AVS_WRITEDATA[15:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (wipe) begin
            for (int i = 0; i < 10; i++) begin
                stage_q[i] <= 16'h0000;
                pend_q[i] <= 16'h0000;
            end
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_PREP) begin
            for (int i = 0; i < 10; i++) begin
                stage_q[i] <= live_q[i];
            end
        end else if (arg_go_q && cmd_q == `SCSC_CMD_STATE) begin
            pend_q[arg_idx_q] <= argw_q;
        end
    end

    // ------------------------------------------------------------------
    // smoothing filters
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (wipe) begin
            weak_q <= 1'b0;
            strg_q <= 1'b0;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_WEAK_ON) begin
            weak_q <= 1'b1;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_WEAK_OFF) begin
            weak_q <= 1'b0;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_STRG_ON) begin
            strg_q <= 1'b1;
        end else if (cmd_go_q && cmd_q == `SCSC_CMD_STRG_OFF) begin
            strg_q <= 1'b0;
        end else if (avw && AVS_ADDRESS == `SCSC_REG_CTRL) begin
            weak_q <= AVS_WRITEDATA[`SCSC_CTRL_WEAK];
            strg_q <= AVS_WRITEDATA[`SCSC_CTRL_STRG];
        end
    end

    // first sample after wipe passes through and seeds the history
    assign s1 = (weak_q && h1_q) ? ema(y1_q, SAMPLE_DATA, `SCSC_WEAK_A) : SAMPLE_DATA;
    assign s2 = (strg_q && h2_q) ? ema(FILT_DATA, s1, `SCSC_STRG_A) : s1;

    always_ff @(posedge CLK) begin
        if (wipe) begin
            h1_q <= 1'b0;
            h2_q <= 1'b0;
            y1_q <= 16'h0000;
            FILT_VALID <= 1'b0;
            FILT_DATA <= 16'h0000;
        end else begin
            FILT_VALID <= SAMPLE_VALID;
            if (SAMPLE_VALID) begin
                h1_q <= weak_q;
                y1_q <= s1;
                h2_q <= strg_q;
                FILT_DATA <= s2;
            end
        end
    end

    // ------------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h00000000;
        if (AVS_ADDRESS == `SCSC_REG_CTRL) begin
            rd_mux[`SCSC_CTRL_TRK] = live_q[`SCSC_W_TRACK][0];
            rd_mux[`SCSC_CTRL_WEAK] = weak_q;
            rd_mux[`SCSC_CTRL_STRG] = strg_q;
            rd_mux[`SCSC_CTRL_BUSY] = st_busy_q;
            rd_mux[`SCSC_CTRL_HOLD] = hold_q;
        end else if (AVS_ADDRESS == `SCSC_REG_TEST) begin
            rd_mux = {16'h0000, test_q};
        end else if (AVS_ADDRESS < `SCSC_REG_LIVE0 + `SCSC_STATE_WORDS) begin
            rd_mux = {16'h0000, live_q[4'(AVS_ADDRESS - `SCSC_REG_LIVE0)]};
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else if (wait_q && (AVS_READ || AVS_WRITE)) begin
            wait_q <= 1'b0;
            rdata_q <= rd_mux;
        end else begin
            wait_q <= 1'b1;
        end
    end
endmodule : scsc_top

// File: scsc_top_tb.sv
// self-checking bench for the calibration and state command block
`timescale 1ns/10ps
`include "scsc_params.svh"
module scsc_top_tb;
    localparam logic [7:0] WH = {`SCSC_DEV_ADDR, 1'b0};
    localparam logic [7:0] RH = {`SCSC_DEV_ADDR, 1'b1};
    logic CLK, RESET, SDA_O, SDA_OE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SLEEP_ENTER;
    logic VDD_OK, SAMPLE_VALID, FILT_VALID, TRACK_EN, scl, host_low, sda, ok;
    logic [1:0] MEM_ERR;
    logic [3:0] AVS_ADDRESS;
    logic [15:0] SAMPLE_DATA, FILT_DATA;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, OFFSET_WORD, rv;
    logic [7:0] rd[$];
    int errors = 0, tests_run = 0, cyc = 0;
    logic [18:0] rows [6] = '{{16'h3fef, 3'h1}, {16'h3fc8, 3'h3}, {16'h3fd5, 3'h7},
                              {16'h3f6e, 3'h6}, {16'h3f49, 3'h4}, {16'h3f54, 3'h0}};
    assign sda = !(host_low | SDA_OE);
    scsc_top #(.ST_CYC(50), .RST_CYC(400)) u_scsc_top (.CLK, .RESET, .SCL_I(scl), .SDA_I(sda),
        .SDA_O, .SDA_OE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
        .AVS_WAITREQUEST, .SLEEP_ENTER, .MEM_ERR, .VDD_OK, .SAMPLE_VALID, .SAMPLE_DATA,
        .FILT_VALID, .FILT_DATA, .TRACK_EN, .OFFSET_WORD);
    scsc_host u_scsc_host (.scl, .sda_low(host_low), .sda);
    initial begin
        CLK = 1'b0;
        forever #5 CLK = !CLK;
    end
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        @(posedge CLK);
        while (AVS_WAITREQUEST) @(posedge CLK);
        rv = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask : av
    task automatic smp(input logic [15:0] x, input logic [15:0] e);
        @(posedge CLK);
        SAMPLE_DATA <= x;
        SAMPLE_VALID <= 1'b1;
        @(posedge CLK);
        SAMPLE_VALID <= 1'b0;
        @(negedge CLK);
        check({FILT_VALID, FILT_DATA}, {1'b1, e});
    endtask : smp
    initial begin
        {RESET, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {3'b100, 36'h0};
        {SLEEP_ENTER, MEM_ERR, VDD_OK, SAMPLE_VALID, SAMPLE_DATA} = {4'h2, 17'h0};
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        av(1'b0, 4'h0, 32'h0);
        check(rv, 32'h0);
        foreach (rows[i]) begin
            u_scsc_host.xfer('{WH, rows[i][18:11], rows[i][10:3]}, 0, rd, ok);
            av(1'b0, 4'h0, 32'h0);
            check(rv[2:0], rows[i][2:0]);
            check(TRACK_EN, rows[i][0]);
        end
        av(1'b1, 4'hc, 32'hffff_ffff);
        av(1'b0, 4'hc, 32'h0);
        check(rv, 32'h0);
        av(1'b1, 4'h0, 32'h2);
        smp(16'd1000, 16'd1000);
        smp(16'd0, 16'd602);
        av(1'b1, 4'h0, 32'h6);
        smp(16'd2000, 16'd1159);
        smp(16'd2000, 16'd1203);
        av(1'b1, 4'h0, 32'h1);
        u_scsc_host.xfer('{WH, 8'h36, 8'h08, 8'h12, 8'h34, u_scsc_host.crc(16'h1234)}, 0, rd, ok);
        check(OFFSET_WORD, {16'h1234, 16'h0});
        u_scsc_host.xfer('{WH, 8'h36, 8'h08, 8'h55, 8'h66, 8'h00}, 0, rd, ok);
        check({ok, OFFSET_WORD}, {1'b0, 16'h1234, 16'h0});
        u_scsc_host.xfer('{WH, 8'h37, 8'h0a}, 0, rd, ok);
        u_scsc_host.xfer('{RH}, 3, rd, ok);
        check({rd[0], rd[1], rd[2]}, {16'h1234, u_scsc_host.crc(16'h1234)});
        u_scsc_host.xfer('{WH, 8'h37, 8'h52}, 0, rd, ok);
        u_scsc_host.xfer('{RH}, 30, rd, ok);
        @(posedge CLK);
        SLEEP_ENTER <= 1'b1;
        @(posedge CLK);
        SLEEP_ENTER <= 1'b0;
        @(negedge CLK);
        check({TRACK_EN, OFFSET_WORD}, 33'h0);
        rd.push_front(8'h33);
        rd.push_front(8'he1);
        rd.push_front(WH);
        u_scsc_host.xfer(rd, 0, rd, ok);
        u_scsc_host.xfer('{WH, 8'h36, 8'h50}, 0, rd, ok);
        check({ok, TRACK_EN, OFFSET_WORD}, {2'b11, 16'h1234, 16'h0000});
        u_scsc_host.xfer('{WH, 8'h36, 8'h5b}, 0, rd, ok);
        repeat (60) @(posedge CLK);
        u_scsc_host.xfer('{RH}, 3, rd, ok);
        check({rd[0], rd[1], rd[2]}, {16'h0005, u_scsc_host.crc(16'h0005)});
        av(1'b1, 4'h0, 32'h1);
        u_scsc_host.xfer('{8'h00, 8'h06}, 0, rd, ok);
        u_scsc_host.xfer('{WH}, 0, rd, ok);
        check({ok, TRACK_EN}, 2'b00);
        repeat (450) @(posedge CLK);
        u_scsc_host.xfer('{WH}, 0, rd, ok);
        check(ok, 1'b1);
        complete_run();
    end
endmodule : scsc_top_tb
